// file: inc/cfgld_pkg.sv
// Shared constants for the configuration loader and its flash-sharing host
package cfgld_pkg;
  localparam int FL_ADDR_W = 16;
  localparam int FL_DATA_W = 16;
  localparam int PAGE_W    = 3;
  localparam int DOUT_W    = 8;
  localparam int MODE_W    = 2;
  localparam logic [1:0] MODE_X1 = 2'h0;
  localparam logic [1:0] MODE_X2 = 2'h1;
  localparam logic [1:0] MODE_X4 = 2'h2;
  localparam logic [1:0] MODE_X8 = 2'h3;
  localparam logic [PAGE_W-1:0] PAGE_DEFAULT = 3'h0;
  // Option-bit area: two words per page, start then length in words
  localparam logic [FL_ADDR_W-1:0] OPT_BASE = 16'h0000;
  localparam logic [FL_ADDR_W-1:0] OPT_MODE = 16'h0010;
  // Flash read access and shift clock half period, in ns
  localparam int FL_ACCESS_NS   = 90;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FL_ACCESS_CYC  = (FL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_NS  = 50;
  localparam int SHIFT_HALF_CYC = SHIFT_HALF_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] FL_ACCESS_CNT  = CNT_W'(FL_ACCESS_CYC);
  localparam logic [CNT_W-1:0] SHIFT_HALF_CNT = CNT_W'(SHIFT_HALF_CYC);
  localparam logic [CNT_W-1:0] STATUS_LOW_CNT = 8'h08;
endpackage

// file: inc/cfgld_if.sv
// Link between configuration loader and the party sharing its flash bus
interface cfgld_if;
  import cfgld_pkg::*;
  logic                 cfg_shift_clock;
  logic [DOUT_W-1:0]    cfg_data;
  logic                 ld_status_oe;
  logic                 fpga_status_oe;
  logic                 fpga_status_line;
  logic                 fpga_reconfig_request_n;
  logic                 fpga_config_complete;
  logic [PAGE_W-1:0]    page_select;
  logic [FL_ADDR_W-1:0] ld_addr;
  logic                 ld_oe_n;
  logic                 ld_bus_en;
  logic [FL_ADDR_W-1:0] hs_addr;
  logic                 hs_oe_n;
  logic                 hs_we_n;
  logic [FL_DATA_W-1:0] hs_wdata;
  logic                 hs_bus_en;
  logic [FL_DATA_W-1:0] fl_rdata;
  // Open-drain status wire: low if either party pulls it
  assign fpga_status_line = ~(ld_status_oe | fpga_status_oe);
  modport loader (output cfg_shift_clock, output cfg_data, output ld_status_oe, input fpga_status_line,
                  input fpga_reconfig_request_n, input fpga_config_complete, input page_select,
                  output ld_addr, output ld_oe_n, output ld_bus_en, input fl_rdata);
  modport host (input cfg_shift_clock, input cfg_data, output fpga_status_oe, input fpga_status_line,
                output fpga_reconfig_request_n, output fpga_config_complete, output page_select,
                output hs_addr, output hs_oe_n, output hs_we_n, output hs_wdata, output hs_bus_en,
                input ld_bus_en, input fl_rdata);
endinterface

// file: logic/cfgld_loader.sv
// Configuration loader: page lookup, flash read, serial/parallel streaming
// Functional notes
// - Drive selected width, unused data lines low
// - Each line independent stream, common clock
// - Data stable for rising shift clock edge; code updates data on the same clk edge that raises the clock
// - Status line low pulse restarts controller
// - Loader owns flash bus, no arbitration
// - Other party floats bus during loader access
// - Flash accessed for options, configuration, programming
// - Release bus and idle after completion
// - Request held low keeps loader in reset
// - Never share flash bus between loaders
// - Other party may rewrite page, reconfigure
// - Eight pages, each for all FPGAs
// - Page sampled on status line rise
// - Three-bit page, top bit MSB, default zero
// - Change page then request reconfiguration
// - Page start and length from option area
// - Paging identical in every output width
module cfgld_loader
  import cfgld_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  cfgld_if.loader   lnk,
  output logic      busy,
  output logic      done
);
  typedef enum logic [6:0] {
    ST_HOLD  = 7'h01,
    ST_MODE  = 7'h02,
    ST_START = 7'h04,
    ST_LEN   = 7'h08,
    ST_FETCH = 7'h10,
    ST_SHIFT = 7'h20,
    ST_IDLE  = 7'h40
  } cfgld_state_type;

  cfgld_state_type state_q;
  logic [2:0] stat_s_q, req_s_q, cdone_s_q;
  logic [PAGE_W-1:0] pg_s1_q, pg_s2_q, page_q;
  logic [MODE_W-1:0] mode_q;
  logic [FL_ADDR_W-1:0] addr_q, left_q;
  logic [CNT_W-1:0] wait_q, half_q, low_q;
  logic [FL_DATA_W-1:0] word_q;
  logic [4:0] bits_q;
  logic [DOUT_W-1:0] data_q;
  logic sclk_q, stat_rise, stat_fall, in_reset;
  logic [4:0] step;

  // Two flops before logic reads status, request, complete and page levels (flash data is read direct); third stage for edges
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_s_q  <= 3'h0;
      req_s_q   <= 3'h0;
      cdone_s_q <= 3'h0;
      pg_s1_q   <= PAGE_DEFAULT;
      pg_s2_q   <= PAGE_DEFAULT;
    end else begin
      stat_s_q  <= {stat_s_q[1:0], lnk.fpga_status_line};
      req_s_q   <= {req_s_q[1:0], lnk.fpga_reconfig_request_n};
      cdone_s_q <= {cdone_s_q[1:0], lnk.fpga_config_complete};
      pg_s1_q   <= lnk.page_select;
      pg_s2_q   <= pg_s1_q;
    end
  end
  assign stat_rise = stat_s_q[1] & ~stat_s_q[2];
  assign stat_fall = ~stat_s_q[1] & stat_s_q[2];
  assign in_reset  = ~req_s_q[1] | ~stat_s_q[1];

  // Bits consumed per shift clock by mode
  always_comb begin
    case (mode_q)
      MODE_X1: step = 5'h01;
      MODE_X2: step = 5'h02;
      MODE_X4: step = 5'h04;
      default: step = 5'h08;
    endcase
  end

  // Hold status low after reset and while reconfiguration is requested
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_q <= STATUS_LOW_CNT;
    end else if (!req_s_q[1]) begin
      low_q <= STATUS_LOW_CNT;
    end else if (low_q != 8'h00) begin
      low_q <= low_q - 8'h01;
    end
  end
  assign lnk.ld_status_oe = (low_q != 8'h00) | ~req_s_q[1];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_HOLD;
      page_q  <= PAGE_DEFAULT;
      mode_q  <= MODE_X1;
      addr_q  <= 16'h0000;
      left_q  <= 16'h0000;
      wait_q  <= 8'h00;
      half_q  <= 8'h00;
      word_q  <= 16'h0000;
      bits_q  <= 5'h00;
      data_q  <= 8'h00;
      sclk_q  <= 1'b0;
    end else if (in_reset || stat_fall) begin
      state_q <= ST_HOLD;
      sclk_q  <= 1'b0;
      data_q  <= 8'h00;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (stat_rise) begin
            page_q  <= pg_s2_q;
            addr_q  <= OPT_MODE;
            wait_q  <= FL_ACCESS_CNT;
            state_q <= ST_MODE;
          end
        end
        ST_MODE: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            mode_q  <= MODE_W'(lnk.fl_rdata);
            addr_q  <= OPT_BASE + FL_ADDR_W'({page_q, 1'b0});
            wait_q  <= FL_ACCESS_CNT;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            word_q  <= lnk.fl_rdata;
            addr_q  <= addr_q + 16'h0001;
            wait_q  <= FL_ACCESS_CNT;
            state_q <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            left_q  <= lnk.fl_rdata;
            addr_q  <= word_q;
            wait_q  <= FL_ACCESS_CNT;
            state_q <= (lnk.fl_rdata == 16'h0000) ? ST_IDLE : ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            word_q  <= lnk.fl_rdata;
            addr_q  <= addr_q + 16'h0001;
            left_q  <= left_q - 16'h0001;
            bits_q  <= 5'h10;
            half_q  <= 8'h00;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (half_q != 8'h00) begin
            half_q <= half_q - 8'h01;
          end else if (!sclk_q) begin
            // Data and the clock rise are registered on the same clk edge; data then holds through the high phase
            if (bits_q == 5'h00) begin
              if (left_q == 16'h0000 || cdone_s_q[1]) begin
                state_q <= ST_IDLE;
              end else begin
                wait_q  <= FL_ACCESS_CNT;
                state_q <= ST_FETCH;
              end
            end else begin
              case (mode_q)
                MODE_X1: data_q <= {7'h00, word_q[0]};
                MODE_X2: data_q <= {6'h00, word_q[1:0]};
                MODE_X4: data_q <= {4'h0, word_q[3:0]};
                default: data_q <= word_q[7:0];
              endcase
              word_q <= word_q >> step;
              bits_q <= bits_q - step;
              sclk_q <= 1'b1;
              half_q <= SHIFT_HALF_CNT - 8'h01;
            end
          end else begin
            sclk_q <= 1'b0;
            half_q <= SHIFT_HALF_CNT - 8'h01;
          end
        end
        ST_IDLE: begin
          sclk_q <= 1'b0;
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // Bus owned only while reading flash; released otherwise
  assign lnk.ld_bus_en = (state_q == ST_MODE) | (state_q == ST_START) | (state_q == ST_LEN) |
                         (state_q == ST_FETCH);
  assign lnk.ld_addr = addr_q;
  assign lnk.ld_oe_n = ~lnk.ld_bus_en;
  assign lnk.cfg_shift_clock = sclk_q;
  assign lnk.cfg_data = data_q;
  assign busy = (state_q != ST_HOLD) & (state_q != ST_IDLE);
  assign done = (state_q == ST_IDLE);
endmodule

// file: logic/cfgld_host.sv
// External party: holds loader off the bus or waits for configuration complete, then reads or writes flash
module cfgld_host
  import cfgld_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  cfgld_if.host                     lnk,
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic [FL_ADDR_W-1:0] req_addr,
  input  wire logic [FL_DATA_W-1:0] req_wdata,
  output logic                      req_ready,
  output logic                      rsp_valid,
  output logic [FL_DATA_W-1:0]      rsp_rdata,
  input  wire logic [PAGE_W-1:0]    new_page,
  input  wire logic                 hold_loader,
  input  wire logic                 fpga_done_in
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_ACC  = 3'h2,
    HS_RESP = 3'h4
  } cfgld_hstate_type;

  cfgld_hstate_type st_q;
  logic [1:0] lbus_s_q, done_d_q;
  logic [CNT_W-1:0] wait_q;
  logic [FL_ADDR_W-1:0] addr_q;
  logic [FL_DATA_W-1:0] wdata_q, rdata_q;
  logic write_q, free;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lbus_s_q <= 2'h3;
      done_d_q <= 2'h0;
    end else begin
      lbus_s_q <= {lbus_s_q[0], lnk.ld_bus_en};
      done_d_q <= {done_d_q[0], fpga_done_in};
    end
  end
  // Loader stops a few cycles after hold, and after done once its current word is shifted; its fetch in flight must end first
  assign free = ~lnk.ld_bus_en & ~lbus_s_q[1] &
                ((hold_loader & ~lnk.fpga_status_line) | (fpga_done_in & done_d_q[1]));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q    <= HS_IDLE;
      wait_q  <= 8'h00;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
      write_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (req_valid && free) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
            wait_q  <= FL_ACCESS_CNT;
            st_q    <= HS_ACC;
          end
        end
        HS_ACC: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            rdata_q <= lnk.fl_rdata;
            st_q    <= HS_RESP;
          end
        end
        HS_RESP: st_q <= HS_IDLE;
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign req_ready = (st_q == HS_IDLE) & free;
  assign rsp_valid = (st_q == HS_RESP);
  assign rsp_rdata = rdata_q;
  assign lnk.hs_bus_en = (st_q == HS_ACC);
  assign lnk.hs_addr = addr_q;
  assign lnk.hs_wdata = wdata_q;
  assign lnk.hs_we_n = ~((st_q == HS_ACC) & write_q);
  assign lnk.hs_oe_n = ~((st_q == HS_ACC) & ~write_q);
  assign lnk.fpga_reconfig_request_n = ~hold_loader;
  assign lnk.page_select = new_page;
  assign lnk.fpga_status_oe = 1'b0;
  assign lnk.fpga_config_complete = fpga_done_in;
endmodule

// file: sim/cfgld_checker.sv
// Concurrent checks on the loader to host link
module cfgld_checker
  import cfgld_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 cfg_shift_clock,
  input wire logic [DOUT_W-1:0]    cfg_data,
  input wire logic                 fpga_status_line,
  input wire logic                 fpga_reconfig_request_n,
  input wire logic                 fpga_config_complete,
  input wire logic [PAGE_W-1:0]    page_select,
  input wire logic [FL_ADDR_W-1:0] ld_addr,
  input wire logic                 ld_bus_en,
  input wire logic                 hs_bus_en,
  input wire logic [FL_DATA_W-1:0] fl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PAGE_W-1:0] pg_q;
  logic              seen_q;
  logic [1:0]        mode_q;
  logic [8:0]        cc_q;
  logic [7:0]        wmask;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  assign wmask = 8'((9'h001 << (4'h1 << mode_q)) - 9'h001);
  // Page and mode as the loader should have taken them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pg_q   <= 3'h0;
      mode_q <= 2'h0;
    end else begin
      if ($rose(fpga_status_line)) begin
        pg_q <= page_select;
      end
      if (ld_bus_en && ld_addr == OPT_MODE) begin
        mode_q <= fl_rdata[1:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else if (ld_bus_en) begin
      seen_q <= (ld_addr == OPT_MODE);
    end
  end
  // Saturating count of cycles with configuration complete
  always_ff @(posedge clk) begin
    if (!rst_b || !fpga_config_complete) begin
      cc_q <= 9'h000;
    end else if (cc_q != 9'h1FF) begin
      cc_q <= cc_q + 9'h001;
    end
  end
  AST_UNUSED_LOW: assert property (cfg_shift_clock |-> (cfg_data & ~wmask) == 8'h00)
    else $error("data line above selected width not low");
  AST_DATA_HOLD: assert property (cfg_shift_clock && $past(cfg_shift_clock) |-> $stable(cfg_data))
    else $error("data moved while shift clock high");
  // A restart may cut a high phase short
  AST_CLK_HIGH: assert property (disable iff (!rst_b || !fpga_reconfig_request_n || !fpga_status_line)
    $rose(cfg_shift_clock) |-> cfg_shift_clock [*5] ##1 !cfg_shift_clock)
    else $error("shift clock high phase wrong");
  AST_NO_OVERLAP: assert property (!(ld_bus_en && hs_bus_en))
    else $error("both parties drive flash bus");
  AST_HOLD_RELEASE: assert property ($fell(fpga_reconfig_request_n) |-> ##[1:4] (!ld_bus_en && !fpga_status_line))
    else $error("loader did not release on request");
  AST_HOLD_STAYS: assert property (!fpga_reconfig_request_n [*4] |-> !ld_bus_en && !fpga_status_line)
    else $error("loader active while request held low");
  AST_START_OPT: assert property ($rose(fpga_status_line) |-> ##[2:4] (ld_bus_en && ld_addr == OPT_MODE))
    else $error("option read did not follow status rise");
  AST_PAGE_START: assert property (ld_bus_en && ld_addr != OPT_MODE && seen_q
                                   |-> ld_addr == FL_ADDR_W'({pg_q, 1'b0}))
    else $error("page pointer fetched from wrong address");
  AST_IDLE_RELEASE: assert property (cc_q >= 9'h0FA |-> !ld_bus_en)
    else $error("loader holds bus when idle");
  AST_HOST_GATED: assert property (hs_bus_en |-> !fpga_reconfig_request_n || fpga_config_complete)
    else $error("host on bus without holding loader");
endmodule

// file: sim/cfgld_bench.sv
// Testbench joining loader and host with a small flash model
module cfgld_bench
  import cfgld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, req_valid, req_write, req_ready, rsp_valid, hold_loader, fpga_done_in, done, busy;
  logic [15:0] req_addr, req_wdata, rsp_rdata;
  logic [2:0]  new_page;
  logic [15:0] mem [64];
  int          failures, n_checks;
  cfgld_if lnk ();
  cfgld_loader cfgld_loader_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .busy(busy), .done(done));
  cfgld_host cfgld_host_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .new_page(new_page), .hold_loader(hold_loader), .fpga_done_in(fpga_done_in));
  cfgld_checker cfgld_checker_inst (.clk(clk), .rst_b(rst_b), .cfg_shift_clock(lnk.cfg_shift_clock),
    .cfg_data(lnk.cfg_data), .fpga_status_line(lnk.fpga_status_line),
    .fpga_reconfig_request_n(lnk.fpga_reconfig_request_n), .fpga_config_complete(lnk.fpga_config_complete),
    .page_select(lnk.page_select), .ld_addr(lnk.ld_addr), .ld_bus_en(lnk.ld_bus_en),
    .hs_bus_en(lnk.hs_bus_en), .fl_rdata(lnk.fl_rdata));
  // Released bus shows the inverse of word 0, not the last read
  assign lnk.fl_rdata = !lnk.ld_oe_n ? mem[lnk.ld_addr[5:0]] : (!lnk.hs_oe_n ? mem[lnk.hs_addr[5:0]] : ~mem[0]);
  always @(posedge clk) if (lnk.hs_bus_en === 1'b1 && lnk.hs_we_n === 1'b0) mem[lnk.hs_addr[5:0]] <= lnk.hs_wdata;
  always #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic host_op(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] rd);
    int i;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    i = 0;
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 300);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      failures++;
      $display("mismatch t=%0t host request not taken", $time);
    end
    i = 0;
    do begin @(posedge clk); i++; end while (rsp_valid !== 1'b1 && i < 40);
    rd = rsp_rdata;
    if (rsp_valid !== 1'b1) begin
      failures++;
      $display("mismatch t=%0t host response missing", $time);
    end
  endtask
  task automatic wait_rise;
    logic pv;
    int   i;
    pv = lnk.cfg_shift_clock;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (lnk.cfg_shift_clock === 1'b1 && pv !== 1'b1) break;
      pv = lnk.cfg_shift_clock;
    end
    if (i >= 2000) begin
      failures++;
      $display("mismatch t=%0t no shift clock rise", $time);
    end
  endtask
  // Host loads a page while loader is held, then the loader streams it
  task automatic run_cfg(input logic [2:0] p, input logic [1:0] m);
    logic [15:0] w [2];
    logic [15:0] rd, sa;
    int          i, j, st;
    w[0] = 16'hC35A ^ {13'h0000, p};
    w[1] = 16'h6E19 ^ {14'h0000, m};
    st = 1 << m;
    sa = 16'h0020 + {12'h000, p, 1'b0};
    hold_loader <= 1'b1;
    new_page <= p;
    host_op(1'b1, OPT_MODE, {14'h0000, m}, rd);
    host_op(1'b1, {12'h000, p, 1'b0}, sa, rd);
    host_op(1'b1, {12'h000, p, 1'b1}, 16'h0002, rd);
    for (i = 0; i < 2; i++) host_op(1'b1, sa + 16'(i), w[i], rd);
    host_op(1'b0, sa + 16'h0001, 16'h0000, rd);
    chk(rd, w[1]);
    hold_loader <= 1'b0;
    // Page moves after the status rise; the loader must keep the old one
    repeat (14) @(posedge clk);
    new_page <= ~p;
    for (i = 0; i < 2; i++) begin
      for (j = 0; j < 16 / st; j++) begin
        wait_rise;
        chk({8'h00, lnk.cfg_data}, (w[i] >> (j * st)) & 16'((17'h00001 << st) - 17'h00001));
      end
    end
    for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk);
    chk({15'h0000, done}, 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task automatic idle_access(input logic [1:0] m);
    logic [15:0] rd;
    fpga_done_in <= 1'b1;
    host_op(1'b0, OPT_MODE, 16'h0000, rd);
    chk(rd, {14'h0000, m});
    repeat (260) @(posedge clk);
    chk({15'h0000, lnk.ld_bus_en}, 16'h0000);
    fpga_done_in <= 1'b0;
  endtask
  // Request falls in mid-stream; loader must drop the bus and hold status low
  task automatic abort_cfg;
    hold_loader <= 1'b1;
    repeat (5) @(posedge clk);
    hold_loader <= 1'b0;
    wait_rise;
    chk({15'h0000, busy}, 16'h0001);
    repeat (7) @(posedge clk);
    hold_loader <= 1'b1;
    repeat (6) @(posedge clk);
    chk({14'h0000, lnk.ld_bus_en, lnk.fpga_status_line}, 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {req_valid, req_write, fpga_done_in} = 3'h0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    new_page = PAGE_DEFAULT;
    hold_loader = 1'b1;
    failures = 0;
    n_checks = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run_cfg(3'h7, MODE_X1);
    run_cfg(3'h1, MODE_X2);
    run_cfg(3'h2, MODE_X4);
    run_cfg(PAGE_DEFAULT, MODE_X8);
    idle_access(MODE_X8);
    abort_cfg;
    run_cfg(3'h5, MODE_X2);
    complete_run;
  end
  initial begin
    #300000;
    failures++;
    $display("mismatch t=%0t watchdog expired", $time);
    complete_run;
  end
endmodule
